/* design/mmri_pkg.sv */
/*
  Shared constants for the multi-motor rotation interlock: policy codes,
  widths, reset values, timing figures and the sequencer state type.
  Assumes a single 100 MHz system clock.
*/
package mmri_pkg;
  localparam int NUM_MOTORS = 4;
  localparam int AUX_SLOTS = 3;
  localparam int NUM_TERMS = 8;
  localparam int TERM_W = 3;
  localparam int MIN_W = 14;
  localparam int CYC_W = 33;

  localparam logic [1:0] POL_NONE = 2'h0;
  localparam logic [1:0] POL_AUX = 2'h1;
  localparam logic [1:0] POL_MAIN = 2'h2;

  localparam logic [1:0] FIRST_RST = 2'h0;
  localparam logic [MIN_W-1:0] MINUTES_RST = 14'h0000;
  localparam logic [MIN_W-1:0] MINUTES_MAX = 14'h3FFF;

  // one minute of run time expressed in clock cycles
  localparam longint unsigned CLK_PERIOD_NS = 10;
  localparam longint unsigned MINUTE_NS = 60_000_000_000;
  localparam logic [CYC_W-1:0] CYCLES_PER_MINUTE = CYC_W'(MINUTE_NS / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    ST_STOP = 2'b00,
    ST_RUN = 2'b01,
    ST_BLOCK = 2'b11
  } mmri_state_e;
endpackage

/* design/mmri_runtime.sv */
/*
  Run-time accumulator: counts clock cycles into whole minutes while
  enabled, saturates at the top and clears on request.
  Assumes the clock enable freezes it and the clear wins over counting.
*/
module mmri_runtime #(
  parameter logic [mmri_pkg::CYC_W-1:0] CYCLES_PER_MINUTE = mmri_pkg::CYCLES_PER_MINUTE
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_count_en,
  input wire logic i_clear,
  output logic [mmri_pkg::MIN_W-1:0] o_minutes
);
  logic [mmri_pkg::CYC_W-1:0] cyc;
  logic [mmri_pkg::CYC_W-1:0] next_cyc;
  logic [mmri_pkg::MIN_W-1:0] next_minutes;

  always_comb begin
    next_cyc = cyc;
    next_minutes = o_minutes;
    if (i_clear) begin
      next_cyc = '0;
      next_minutes = mmri_pkg::MINUTES_RST;
    end else if (i_count_en) begin
      if (cyc >= CYCLES_PER_MINUTE - 33'h1) begin
        next_cyc = '0;
        // saturate so a forgotten rotation never wraps back to zero
        if (o_minutes != mmri_pkg::MINUTES_MAX) begin
          next_minutes = o_minutes + 14'h1;
        end
      end else begin
        next_cyc = cyc + 33'h1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cyc <= '0;
      o_minutes <= mmri_pkg::MINUTES_RST;
    end else if (i_ce) begin
      cyc <= next_cyc;
      o_minutes <= next_minutes;
    end
  end
endmodule

/* design/mmri_sequencer.sv */
/*
  Pump motor sequencer: rotation of the start order by run time under
  policies 1 and 2, lockout of faulted motors with substitution, drive
  output hand-over and ordered switching of the auxiliary outputs.
  Assumes start/stop demand and aux count come from outside logic and all
  inputs are synchronous to i_clk.
*/
// Behaviour
// - policy 0: fixed order from selected motor
// - policy 1: flag when run time exceeds limit
// - policy 1: stop/sleep after flag advances first
// - policy 2: flag on drive motor run time
// - policy 2: first motor on drive, rest cyclic
// - policy 2: flagged stop, restart with next motor
// - four lockouts mapped onto selectable terminals
// - policy 0/1: lockouts 1-3 on three aux outputs
// - policy 2: lockouts 1-4 on four outputs
// - lockouts act only when enabled
// - locked idle motor skipped, restored on release
// - policy 2: drive motor lockout blocks, hands over
// - released drive motor joins end of order
// - substitute chosen by current policy
// - aux motors stop in reverse start order
module mmri_sequencer #(
  parameter logic [mmri_pkg::CYC_W-1:0] CYCLES_PER_MINUTE = mmri_pkg::CYCLES_PER_MINUTE
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [1:0] i_rotation_policy_select,
  input wire logic [1:0] i_first_aux_motor_select,
  input wire logic [mmri_pkg::MIN_W-1:0] i_rotation_time_limit,
  input wire logic i_lockout_enable,
  input wire logic [mmri_pkg::NUM_TERMS-1:0] i_input_terminals,
  input wire logic [4*mmri_pkg::TERM_W-1:0] i_input_terminal_function,
  input wire logic [3:0] i_lockout_map_enable,
  input wire logic i_run,
  input wire logic i_sleep,
  input wire logic [1:0] i_aux_demand,
  output logic [mmri_pkg::NUM_MOTORS-1:0] o_motor_on,
  output logic o_drive_connect,
  output logic o_drive_block,
  output logic [1:0] o_drive_motor,
  output logic o_rotation_flag,
  output logic [1:0] o_first_motor,
  output logic [1:0] o_aux_count
);
  mmri_pkg::mmri_state_e state;
  mmri_pkg::mmri_state_e next_state;
  logic [1:0] next_first_motor;
  logic [1:0] sel_q;
  logic [1:0] pol_q;
  logic [mmri_pkg::NUM_MOTORS-1:0] next_motor_on;
  logic next_drive_connect;
  logic next_drive_block;
  logic [1:0] next_drive_motor;
  logic next_rotation_flag;
  logic [1:0] next_aux_count;
  logic [3:0] lockout_raw;
  logic [3:0] lk;
  logic [mmri_pkg::MIN_W-1:0] minutes;
  logic rot_clear;
  logic stop_req;
  logic cfg_change;
  logic [1:0] sel_slot;
  logic pol_main;

  // lockout k follows the terminal its function code selects
  for (genvar k = 0; k < 4; k++) begin : g_lockout_map
    assign lockout_raw[k] = i_lockout_map_enable[k] &
      i_input_terminals[i_input_terminal_function[k*mmri_pkg::TERM_W +: mmri_pkg::TERM_W]];
  end

  // policy 0/1 only has three aux outputs; lockout 4 is meaningless there
  assign pol_main = (i_rotation_policy_select == mmri_pkg::POL_MAIN);
  assign lk = i_lockout_enable ? (pol_main ? lockout_raw : {1'b0, lockout_raw[2:0]})
                               : 4'h0;
  assign sel_slot = (!pol_main && i_first_aux_motor_select == 2'h3) ? 2'h0
                                                                     : i_first_aux_motor_select;
  assign stop_req = !i_run || i_sleep;
  assign cfg_change = (sel_q != i_first_aux_motor_select) || (pol_q != i_rotation_policy_select);

  mmri_runtime #(
    .CYCLES_PER_MINUTE(CYCLES_PER_MINUTE)
  ) u_runtime (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_count_en(state == mmri_pkg::ST_RUN),
    .i_clear(rot_clear),
    .o_minutes(minutes)
  );

  always_comb begin
    int cnt;
    int m;
    logic found;
    cnt = 0;
    m = 0;
    found = 1'b0;
    next_state = state;
    next_first_motor = o_first_motor;
    next_motor_on = '0;
    next_drive_block = 1'b0;
    rot_clear = 1'b0;
    // drive-motor time (policy 2) or main+aux time (policy 1): both run with the drive
    next_rotation_flag = (i_rotation_policy_select != mmri_pkg::POL_NONE) &&
                         (minutes > i_rotation_time_limit);
    if (i_rotation_policy_select == mmri_pkg::POL_NONE || cfg_change) begin
      next_first_motor = sel_slot;
    end
    unique case (state)
      mmri_pkg::ST_STOP: begin
        if (!stop_req) begin
          next_state = mmri_pkg::ST_RUN;
        end
      end
      mmri_pkg::ST_RUN: begin
        if (stop_req) begin
          next_state = mmri_pkg::ST_STOP;
          if (o_rotation_flag && !cfg_change) begin
            if (i_rotation_policy_select == mmri_pkg::POL_AUX) begin
              next_first_motor = (o_first_motor == 2'h2) ? 2'h0 : o_first_motor + 2'h1;
              rot_clear = 1'b1;
            end else if (pol_main) begin
              next_first_motor = o_first_motor + 2'h1;
              rot_clear = 1'b1;
            end
          end
        end else if (pol_main && lk[o_first_motor]) begin
          next_state = mmri_pkg::ST_BLOCK;
        end
      end
      mmri_pkg::ST_BLOCK: begin
        next_drive_block = 1'b1;
        // search the motors after the blocked one; none free keeps the drive dark
        for (int k = 1; k < mmri_pkg::NUM_MOTORS; k++) begin
          m = (int'(o_first_motor) + k) % mmri_pkg::NUM_MOTORS;
          if (!found && !lk[m]) begin
            found = 1'b1;
            next_first_motor = 2'(m);
          end
        end
        if (!lk[o_first_motor]) begin
          next_state = mmri_pkg::ST_RUN;
          next_first_motor = o_first_motor;
        end else if (found) begin
          next_state = mmri_pkg::ST_RUN;
        end
        if (stop_req) begin
          next_state = mmri_pkg::ST_STOP;
        end
      end
      default: begin
        next_state = mmri_pkg::ST_STOP;
      end
    endcase
    // a start or reselection must never close the drive onto a locked motor
    if (pol_main && next_state == mmri_pkg::ST_RUN && lk[next_first_motor]) begin
      next_state = mmri_pkg::ST_BLOCK;
    end
    // walk the start order, skip locked motors, take as many as demanded
    if (state == mmri_pkg::ST_RUN && next_state == mmri_pkg::ST_RUN) begin
      for (int k = 0; k < mmri_pkg::AUX_SLOTS; k++) begin
        if (pol_main) begin
          m = (int'(o_first_motor) + 1 + k) % mmri_pkg::NUM_MOTORS;
        end else begin
          m = (int'(o_first_motor) + k) % mmri_pkg::AUX_SLOTS;
        end
        // trimming the tail of the order stops motors last-on first-off
        if (!lk[m] && cnt < int'(i_aux_demand)) begin
          next_motor_on[m] = 1'b1;
          cnt = cnt + 1;
        end
      end
    end
    next_aux_count = 2'(cnt);
    next_drive_connect = (next_state == mmri_pkg::ST_RUN);
    next_drive_motor = pol_main ? next_first_motor : 2'h0;
    if (pol_main && next_drive_connect) begin
      next_motor_on[next_first_motor] = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= mmri_pkg::ST_STOP;
      o_first_motor <= mmri_pkg::FIRST_RST;
      sel_q <= mmri_pkg::FIRST_RST;
      pol_q <= mmri_pkg::POL_NONE;
      o_motor_on <= '0;
      o_drive_connect <= 1'b0;
      o_drive_block <= 1'b0;
      o_drive_motor <= mmri_pkg::FIRST_RST;
      o_rotation_flag <= 1'b0;
      o_aux_count <= 2'h0;
    end else if (i_ce) begin
      state <= next_state;
      o_first_motor <= next_first_motor;
      sel_q <= i_first_aux_motor_select;
      pol_q <= i_rotation_policy_select;
      o_motor_on <= next_motor_on;
      o_drive_connect <= next_drive_connect;
      o_drive_block <= next_drive_block;
      o_drive_motor <= next_drive_motor;
      o_rotation_flag <= next_rotation_flag;
      o_aux_count <= next_aux_count;
    end
  end

  property p_pol0_fixed;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_ce && i_rotation_policy_select == mmri_pkg::POL_NONE) |=> (o_first_motor == $past(sel_slot));
  endproperty
  a_pol0_fixed: assert property (p_pol0_fixed) else $error("policy 0 order moved");

  property p_pol0_noflag;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_ce && i_rotation_policy_select == mmri_pkg::POL_NONE) |=> !o_rotation_flag;
  endproperty
  a_pol0_noflag: assert property (p_pol0_noflag) else $error("flag under policy 0");

  property p_flag_aux;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_ce && i_rotation_policy_select == mmri_pkg::POL_AUX && minutes > i_rotation_time_limit)
      |=> o_rotation_flag;
  endproperty
  a_flag_aux: assert property (p_flag_aux) else $error("policy 1 flag missing");

  property p_flag_main;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_ce && pol_main && minutes > i_rotation_time_limit) |=> o_rotation_flag;
  endproperty
  a_flag_main: assert property (p_flag_main) else $error("policy 2 flag missing");

  property p_advance_aux;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_ce && state == mmri_pkg::ST_RUN && stop_req && o_rotation_flag && !cfg_change &&
       i_rotation_policy_select == mmri_pkg::POL_AUX)
      |=> (o_first_motor == (($past(o_first_motor) == 2'h2) ? 2'h0 : $past(o_first_motor) + 2'h1))
          && state == mmri_pkg::ST_STOP;
  endproperty
  a_advance_aux: assert property (p_advance_aux) else $error("policy 1 advance wrong");

  property p_clear_on_rotate;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_ce && rot_clear) |=> (minutes == mmri_pkg::MINUTES_RST);
  endproperty
  a_clear_on_rotate: assert property (p_clear_on_rotate) else $error("run time not cleared");

  property p_drive_block;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_ce && state == mmri_pkg::ST_RUN && !stop_req && pol_main && lk[o_first_motor])
      |=> !o_drive_connect ##1 (!i_ce || o_drive_block);
  endproperty
  a_drive_block: assert property (p_drive_block) else $error("drive not blocked");

  property p_locked_off;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_ce && lk != 4'h0) |=> ((o_motor_on & $past(lk)) == 4'h0);
  endproperty
  a_locked_off: assert property (p_locked_off) else $error("locked motor switched on");

  property p_demand_cap;
    @(posedge i_clk) disable iff (!i_rstn)
      i_ce |=> (o_aux_count <= $past(i_aux_demand));
  endproperty
  a_demand_cap: assert property (p_demand_cap) else $error("too many aux motors");

  property p_rotate_main;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_ce && state == mmri_pkg::ST_RUN && stop_req && o_rotation_flag && !cfg_change &&
       pol_main)
      |=> (o_first_motor == $past(o_first_motor) + 2'h1) && state == mmri_pkg::ST_STOP;
  endproperty
  a_rotate_main: assert property (p_rotate_main) else $error("policy 2 rotation wrong");

  property p_block_empty;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_ce && state == mmri_pkg::ST_BLOCK && lk == 4'hF && !stop_req)
      |=> (state == mmri_pkg::ST_BLOCK && o_motor_on == 4'h0 && !o_drive_connect);
  endproperty
  a_block_empty: assert property (p_block_empty) else $error("faulted motor started");

  property p_drive_on;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_ce && pol_main) |=> (!o_drive_connect || o_motor_on[o_drive_motor]);
  endproperty
  a_drive_on: assert property (p_drive_on) else $error("drive motor not switched");

  property p_aux_count;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_ce && !pol_main) |=> (o_aux_count == 2'($countones(o_motor_on)));
  endproperty
  a_aux_count: assert property (p_aux_count) else $error("aux count mismatch");

  property p_no_fourth;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_ce && !pol_main) |=> !o_motor_on[3];
  endproperty
  a_no_fourth: assert property (p_no_fourth) else $error("fourth output under policy 0/1");

  property p_stop_off;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_ce && stop_req) |=> (o_motor_on == 4'h0 && !o_drive_connect);
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("motors left on at stop");
endmodule

/* tb/mmri_motor_bank.sv */
/*
  Motor bank model: turns the bench's per-motor fault requests into
  terminal levels. Assumes lockout k is wired to terminal 4+k.
*/
module mmri_motor_bank (
  input wire logic i_clk,
  input wire logic [3:0] i_fault,
  output logic [7:0] o_terminals
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] spare = 4'h5;
  // unmapped terminals keep moving so a wrong map shows as a false lockout
  always_ff @(posedge i_clk) begin
    spare <= ~spare ^ {3'h0, spare[3]};
  end
  assign o_terminals = {i_fault, spare};
endmodule

/* tb/test_multi_motor_rotation_interlock.sv */
/*
  Bench for the motor sequencer: drives policy, demand and faults and
  compares outputs with an integer model. Assumes a 100 MHz clock.
*/
module test_multi_motor_rotation_interlock;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [1:0] pol = 2'h0;
  logic [1:0] sel = 2'h0;
  logic lke = 1'b0;
  logic ce = 1'b1;
  logic run = 1'b0;
  logic slp = 1'b0;
  logic [1:0] dem = 2'h0;
  logic [3:0] fault = 4'h0;
  logic [7:0] terms;
  logic [3:0] on;
  logic dcon, dblk, flag;
  logic [1:0] dmot, first, acnt;
  logic [31:0] seed = 32'hF9907A93;
  int failures = 0;
  int comparisons = 0;
  int mf = 0;

  mmri_motor_bank bank_u (.i_clk(i_clk), .i_fault(fault), .o_terminals(terms));
  // ten cycles to the minute keeps the rotation waits short
  mmri_sequencer #(.CYCLES_PER_MINUTE(33'h00000000A)) dut_u (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_ce(ce), .i_rotation_policy_select(pol),
    .i_first_aux_motor_select(sel), .i_rotation_time_limit(14'h0001),
    .i_lockout_enable(lke), .i_input_terminals(terms), .i_input_terminal_function(12'hFAC),
    .i_lockout_map_enable(4'hF), .i_run(run), .i_sleep(slp), .i_aux_demand(dem),
    .o_motor_on(on), .o_drive_connect(dcon), .o_drive_block(dblk), .o_drive_motor(dmot),
    .o_rotation_flag(flag), .o_first_motor(first), .o_aux_count(acnt));

  initial begin
    forever #5 i_clk = ~i_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // walk from the first motor, skipping locked ones; policy 2 adds the drive
  function automatic logic [3:0] exp_on(input int p, input int f, input int d,
                                        input logic [3:0] lk);
    int n, c, idx;
    logic [3:0] r;
    n = (p == 2) ? 4 : 3;
    c = (p == 2) ? d + 1 : d;
    r = 4'h0;
    for (int k = 0; k < n; k++) begin
      idx = (f + k) % n;
      if (!lk[idx] && c > 0) begin
        r[idx] = 1'b1;
        c--;
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] cur(input int w);
    case (w)
      0: return on;
      1: return {2'h0, first};
      2: return {2'h0, dmot};
      3: return {3'h0, flag};
      4: return {2'h0, acnt};
      5: return {3'h0, dcon};
      default: return {3'h0, dblk};
    endcase
  endfunction

  task automatic test_done();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic expect_v(input int w, input logic [3:0] e);
    int t;
    t = 0;
    @(negedge i_clk);
    while (cur(w) !== e && t < 300) begin
      @(negedge i_clk);
      t++;
    end
    comparisons++;
    if (cur(w) !== e) begin
      failures++;
      $display("[ERR] %0t output %0d is %h, expected %h", $time, w, cur(w), e);
      test_done();
    end
    @(posedge i_clk);
  endtask

  task automatic go(input int p, input int s, input int d, input logic [3:0] lk);
    @(posedge i_clk);
    run <= 1'b0;
    repeat (3) @(posedge i_clk);
    pol <= p[1:0];
    sel <= s[1:0];
    dem <= d[1:0];
    fault <= lk;
    repeat (3) @(posedge i_clk);
    run <= 1'b1;
    mf = s;
  endtask

  initial begin
    logic [3:0] e;
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'b1;
    expect_v(0, 4'h0);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      lke <= seed[7];
      go(0, seed[1:0] % 3, seed[3:2], {1'b0, seed[6:4]});
      e = exp_on(0, mf, seed[3:2], {1'b0, seed[6:4]} & {4{seed[7]}});
      expect_v(0, e);
      expect_v(4, 4'($countones(e)));
      expect_v(1, 4'(mf));
    end
    lke <= 1'b1;
    go(1, 2, 1, 4'h0);
    expect_v(0, 4'h4);
    dem <= 2'h3;
    expect_v(0, 4'h7);
    dem <= 2'h2;
    expect_v(0, 4'h5);
    fault <= 4'h1;
    expect_v(0, 4'h6);
    fault <= 4'h0;
    expect_v(0, 4'h5);
    expect_v(3, 4'h1);
    slp <= 1'b1;
    expect_v(1, 4'h0);
    expect_v(3, 4'h0);
    slp <= 1'b0;
    dem <= 2'h1;
    expect_v(0, 4'h1);
    go(2, 1, 2, 4'h0);
    expect_v(0, exp_on(2, mf, 2, 4'h0));
    expect_v(2, 4'h1);
    expect_v(5, 4'h1);
    expect_v(3, 4'h1);
    run <= 1'b0;
    expect_v(0, 4'h0);
    expect_v(5, 4'h0);
    run <= 1'b1;
    mf = 2;
    expect_v(0, exp_on(2, mf, 2, 4'h0));
    expect_v(2, 4'h2);
    fault <= 4'h4;
    mf = 3;
    expect_v(0, exp_on(2, mf, 2, 4'h4));
    expect_v(2, 4'h3);
    fault <= 4'h0;
    dem <= 2'h3;
    expect_v(0, exp_on(2, mf, 3, 4'h0));
    expect_v(2, 4'h3);
    fault <= 4'hF;
    expect_v(6, 4'h1);
    expect_v(0, 4'h0);
    expect_v(5, 4'h0);
    fault <= 4'h0;
    expect_v(0, exp_on(2, mf, 3, 4'h0));
    expect_v(6, 4'h0);
    // enable low must hold the outputs although the demand drops
    ce <= 1'b0;
    dem <= 2'h1;
    repeat (4) @(posedge i_clk);
    expect_v(0, exp_on(2, mf, 3, 4'h0));
    ce <= 1'b1;
    expect_v(0, exp_on(2, mf, 1, 4'h0));
    test_done();
  end
endmodule
